// ===== core/tx_defs.vh
// constants for the transmitter status and channel bank logic
`ifndef TX_DEFS_VH
`define TX_DEFS_VH

// register map
`define REG_LAST 7'h27
`define REG_STATUS 7'h01
`define REG_COUNT 40
`define BANK_A_BASE 6'h09
`define CMD_READ_BIT 7

// status register bit positions
`define ST_CLOSE_BIT 5
`define ST_EARLY_BIT 4
`define ST_BROWN_BIT 2
`define ST_PAR_BIT 1
`define ST_LOCK_BIT 0
`define ST_FIXED 8'h80

// sticky flag vector: {close, early, brown, parity, lock}
`define FL_CLOSE 4
`define FL_EARLY 3
`define FL_BROWN 2
`define FL_PAR 1
`define FL_LOCK 0
`define FL_RESET 5'h04

// serial framing, in clock edges of the serial clock
`define CMD_LAST 4'h7
`define WR_LAST 4'h8
`define RD_LAST 4'h7

// synthesizer lock timing
`define CLK_HZ 20000000
`define LOCK_TYP_US 20
`define LOCK_MAX_US 100
`define LOCK_TYP_CYC ((`LOCK_TYP_US * `CLK_HZ) / 1000000)
`define LOCK_MAX_CYC ((`LOCK_MAX_US * `CLK_HZ) / 1000000)
`define LOCK_CNT_W 11

`endif

// ===== core/lock_timer.v
// synthesizer lock watchdog started on each synth_word load from a bank
`timescale 1ns/100ps
`include "tx_defs.vh"

module lock_timer (
    input wire clk_sys, // system clock, 20 MHz
    input wire rst_n, // asynchronous reset, active low
    input wire start, // pulse: new frequency loaded
    input wire abort, // pulse: stop watching
    input wire synth_lock, // lock indication from synthesizer
    output reg locked, // pulse: lock seen in time
    output reg fault // pulse: no lock within the bound
);

localparam integer CNT_LAST_I = `LOCK_MAX_CYC - 1;
localparam [`LOCK_CNT_W-1:0] CNT_LAST = CNT_LAST_I[`LOCK_CNT_W-1:0];

reg busy_ff;
reg [`LOCK_CNT_W-1:0] cnt_ff;

//--------------------------------------------------------------
// watchdog
//--------------------------------------------------------------
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        busy_ff <= 1'b0;
        cnt_ff <= {`LOCK_CNT_W{1'b0}};
        locked <= 1'b0;
        fault <= 1'b0;
    end else begin
        locked <= 1'b0;
        fault <= 1'b0;
        if (abort) begin
            busy_ff <= 1'b0;
        end else if (start) begin
            busy_ff <= 1'b1;
            cnt_ff <= {`LOCK_CNT_W{1'b0}};
        end else if (busy_ff) begin
            if (synth_lock) begin
                locked <= 1'b1;
                busy_ff <= 1'b0;
            end else if (cnt_ff == CNT_LAST) begin
                fault <= 1'b1;
                busy_ff <= 1'b0;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end
end

endmodule // lock_timer

// ===== core/tx_regs.v
// serial register bank, channel banks, supply monitor and status flags
`timescale 1ns/100ps
`include "tx_defs.vh"

module tx_regs (
    input wire clk_sys, // system clock, 20 MHz
    input wire rst_n, // asynchronous reset, active low
    input wire spi_cs_n, // serial chip select, active low
    input wire spi_sck, // serial clock, mode 0
    input wire spi_mosi, // serial data in
    output reg spi_miso, // serial data out
    output reg spi_miso_oe, // high while miso is driven
    input wire osc_ready, // reference oscillator settled
    input wire standby, // device in standby
    input wire tx_start, // pulse: start transmission
    input wire [1:0] bank_sel, // bank to use with tx_start
    input wire tx_stop, // pulse: end transmission
    input wire synth_lock, // synthesizer lock level
    input wire below_2v4, // supply under early warning level
    input wire below_2v1, // supply under close warning level
    input wire below_1v75, // supply under brownout level
    output reg [31:0] synth_word, // frequency setting of bank
    output reg synth_load, // pulse: synth_word newly loaded
    output reg tx_enable, // transmitter on
    output reg force_reset // forced internal reset active
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_LOCKING = 3'h1;
localparam [2:0] ST_TX = 3'h2;
localparam [2:0] ST_ABORT = 3'h3;
localparam [2:0] ST_FRESET = 3'h4;

function [5:0] bank_idx;
    input [1:0] bank;
    input [1:0] k;
    begin
        bank_idx = `BANK_A_BASE + {2'b00, bank, 2'b00} + {4'h0, k};
    end
endfunction

function in_map;
    input [6:0] a;
    begin
        in_map = (a <= `REG_LAST);
    end
endfunction

reg [7:0] regs_ff [0:`REG_COUNT-1];
reg [4:0] flags_ff;
reg [2:0] state_ff;
reg [2:0] nxt_state;
reg sck_q_ff;
reg in_data_ff;
reg rw_ff;
reg load_ff;
reg [6:0] addr_ff;
reg [3:0] cnt_ff;
reg [7:0] rx_ff;
reg [7:0] tx_ff;
reg wr_stb_ff;
reg [6:0] wr_addr_ff;
reg [7:0] wr_data_ff;
reg par_set_ff;
wire rd_clr;
wire sck_rise;
wire sck_fall;
wire freset;
wire lock_ok;
wire lock_fault;
wire [7:0] status_byte;
wire [7:0] rd_val;
wire [4:0] set_vec;
integer i;

assign sck_rise = spi_sck & ~sck_q_ff;
assign sck_fall = ~spi_sck & sck_q_ff;
assign freset = (state_ff == ST_FRESET);

// clear on read, in the cycle the byte is taken, so a pulse
// event landing in that cycle is kept rather than lost
assign rd_clr = load_ff & ~spi_cs_n & ~freset &
    (addr_ff == `REG_STATUS);

assign status_byte = `ST_FIXED
    | ({7'h00, flags_ff[`FL_CLOSE]} << `ST_CLOSE_BIT)
    | ({7'h00, flags_ff[`FL_EARLY]} << `ST_EARLY_BIT)
    | ({7'h00, flags_ff[`FL_BROWN]} << `ST_BROWN_BIT)
    | ({7'h00, flags_ff[`FL_PAR]} << `ST_PAR_BIT)
    | ({7'h00, flags_ff[`FL_LOCK]} << `ST_LOCK_BIT);

// reads outside the map return zero
assign rd_val = (addr_ff == `REG_STATUS) ? status_byte :
    in_map(addr_ff) ? regs_ff[addr_ff[5:0]] : 8'h00;

//--------------------------------------------------------------
// serial slave
//--------------------------------------------------------------
// inputs are synchronous, so edges are found by one delay stage;
// the serial clock must stay at least two clocks in each phase
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        sck_q_ff <= 1'b0;
        in_data_ff <= 1'b0;
        rw_ff <= 1'b0;
        load_ff <= 1'b0;
        addr_ff <= 7'h00;
        cnt_ff <= 4'h0;
        rx_ff <= 8'h00;
        tx_ff <= 8'h00;
        spi_miso <= 1'b0;
        spi_miso_oe <= 1'b0;
        wr_stb_ff <= 1'b0;
        wr_addr_ff <= 7'h00;
        wr_data_ff <= 8'h00;
        par_set_ff <= 1'b0;
    end else begin
        sck_q_ff <= spi_sck;
        spi_miso_oe <= ~spi_cs_n;
        wr_stb_ff <= 1'b0;
        par_set_ff <= 1'b0;
        if (spi_cs_n || freset) begin
            in_data_ff <= 1'b0;
            load_ff <= 1'b0;
            cnt_ff <= 4'h0;
        end else if (load_ff) begin
            load_ff <= 1'b0;
            spi_miso <= rd_val[7];
            tx_ff <= {rd_val[6:0], 1'b0};
        end else if (sck_rise) begin
            rx_ff <= {rx_ff[6:0], spi_mosi};
            cnt_ff <= cnt_ff + 1'b1;
            if (!in_data_ff) begin
                if (cnt_ff == `CMD_LAST) begin
                    in_data_ff <= 1'b1;
                    cnt_ff <= 4'h0;
                    rw_ff <= rx_ff[`CMD_READ_BIT - 1];
                    addr_ff <= {rx_ff[5:0], spi_mosi};
                    load_ff <= rx_ff[`CMD_READ_BIT - 1];
                end
            end else if (rw_ff) begin
                if (cnt_ff == `RD_LAST) begin
                    cnt_ff <= 4'h0;
                    addr_ff <= addr_ff + 1'b1;
                    load_ff <= 1'b1;
                end
            end else if (cnt_ff == `WR_LAST) begin
                // burst write, address steps per byte
                cnt_ff <= 4'h0;
                addr_ff <= addr_ff + 1'b1;
                if (^{rx_ff, spi_mosi}) begin
                    wr_stb_ff <= 1'b1;
                    wr_addr_ff <= addr_ff;
                    wr_data_ff <= rx_ff;
                end else begin
                    par_set_ff <= 1'b1;
                end
            end
        end else if (sck_fall && in_data_ff && rw_ff && cnt_ff != 4'h0) begin
            spi_miso <= tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b0};
        end
    end
end

//--------------------------------------------------------------
// register array
//--------------------------------------------------------------
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        for (i = 0; i < `REG_COUNT; i = i + 1) begin
            regs_ff[i] <= 8'h00;
        end
    end else if (freset) begin
        for (i = 0; i < `REG_COUNT; i = i + 1) begin
            regs_ff[i] <= 8'h00;
        end
    end else if (wr_stb_ff && in_map(wr_addr_ff) &&
                 wr_addr_ff != `REG_STATUS) begin
        // banks live in the map, written like any register
        regs_ff[wr_addr_ff[5:0]] <= wr_data_ff;
    end
end

//--------------------------------------------------------------
// status flags
//--------------------------------------------------------------
// warnings raised while running
// each event has its own flag
assign set_vec[`FL_CLOSE] = below_2v1 & ~standby;
assign set_vec[`FL_EARLY] = below_2v4 & ~standby;
assign set_vec[`FL_BROWN] = (state_ff == ST_ABORT) | freset;
assign set_vec[`FL_PAR] = par_set_ff;
assign set_vec[`FL_LOCK] = lock_fault;

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        flags_ff <= `FL_RESET;
    end else if (rd_clr || freset) begin
        // clear on read, a new event wins over the clear
        flags_ff <= set_vec;
    end else begin
        flags_ff <= flags_ff | set_vec;
    end
end

//--------------------------------------------------------------
// transmit sequencing
//--------------------------------------------------------------
always @* begin
    nxt_state = state_ff;
    case (state_ff)
        ST_IDLE: begin
            if (tx_start && osc_ready && !standby) begin
                nxt_state = ST_LOCKING;
            end
        end
        ST_LOCKING: begin
            if (lock_ok) begin
                nxt_state = ST_TX;
            end else if (lock_fault) begin
                nxt_state = ST_IDLE;
            end
        end
        ST_TX: begin
            if (tx_stop) begin
                nxt_state = ST_IDLE;
            end
        end
        ST_ABORT: begin
            nxt_state = ST_FRESET;
        end
        ST_FRESET: begin
            if (!below_1v75) begin
                nxt_state = ST_IDLE;
            end
        end
        default: begin
            nxt_state = ST_IDLE;
        end
    endcase
    if (below_1v75 && state_ff != ST_ABORT && state_ff != ST_FRESET) begin
        nxt_state = ST_ABORT;
    end
end

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        state_ff <= ST_IDLE;
        synth_word <= 32'h0000_0000;
        synth_load <= 1'b0;
        tx_enable <= 1'b0;
        force_reset <= 1'b0;
    end else begin
        state_ff <= nxt_state;
        synth_load <= 1'b0;
        tx_enable <= (nxt_state == ST_TX);
        force_reset <= (nxt_state == ST_FRESET);
        if (state_ff == ST_IDLE && nxt_state == ST_LOCKING) begin
            // full setting taken from the chosen bank
            synth_word <= {regs_ff[bank_idx(bank_sel, 2'd0)],
                           regs_ff[bank_idx(bank_sel, 2'd1)],
                           regs_ff[bank_idx(bank_sel, 2'd2)],
                           regs_ff[bank_idx(bank_sel, 2'd3)]};
            synth_load <= 1'b1;
        end
    end
end

lock_timer u_lock_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(synth_load),
    .abort(state_ff == ST_ABORT),
    .synth_lock(synth_lock),
    .locked(lock_ok),
    .fault(lock_fault)
);

endmodule // tx_regs

// ===== bench/tx_regs_asserts.sv
// port checks for the status and channel bank block
`timescale 1ns/100ps
module tx_regs_asserts (
    input wire clk_sys, // clock
    input wire rst_n, // reset
    input wire spi_cs_n, // select
    input wire spi_miso_oe, // miso on
    input wire osc_ready, // osc ok
    input wire standby, // standby
    input wire tx_start, // start
    input wire synth_lock, // lock
    input wire below_1v75, // brownout
    input wire synth_load, // loaded
    input wire tx_enable, // tx on
    input wire force_reset // forced reset
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_load_cause: assert property (
        synth_load |-> $past(tx_start) && $past(osc_ready) &&
            !$past(standby))
        else $error("load without start");
    chk_load_pulse: assert property (
        synth_load |=> !synth_load)
        else $error("load too long");
    chk_tx_locked: assert property (
        $rose(tx_enable) |-> synth_lock && $past(synth_lock))
        else $error("tx without lock");
    chk_brown_abort: assert property (
        below_1v75 |=> !tx_enable)
        else $error("tx kept in brownout");
    chk_reset_after: assert property (
        $rose(force_reset) |-> !tx_enable && $past(below_1v75, 2))
        else $error("reset without abort");
    chk_reset_held: assert property (
        below_1v75 && force_reset |=> force_reset)
        else $error("reset dropped early");
    chk_reset_quiet: assert property (
        force_reset |-> !tx_enable && !synth_load)
        else $error("activity in reset");
    // a late or stuck enable would corrupt the shared data line
    chk_oe_follows: assert property (
        $past(rst_n) |-> spi_miso_oe == !$past(spi_cs_n))
        else $error("miso enable wrong");
    cover property ($rose(tx_enable));
    cover property ($rose(force_reset));
    cover property (synth_load);
endmodule // tx_regs_asserts

// ===== bench/spi_host.sv
// host side serial master model
`timescale 1ns/100ps
module spi_host (
    input wire clk_sys, // clock
    output logic spi_cs_n, // select
    output logic spi_sck, // serial clock
    output logic spi_mosi, // data out
    input wire spi_miso, // data in
    input wire spi_miso_oe // miso on
);
    logic [7:0] dat [0:15];
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_mosi = 1'b0;
    end
    // four clocks a phase, twice the minimum, for margin
    task automatic sbit(input logic b, output logic q);
        spi_mosi = b;
        repeat (4) @(posedge clk_sys);
        #1 spi_sck = 1'b1;
        q = spi_miso_oe ? spi_miso : 1'bx;
        repeat (4) @(posedge clk_sys);
        #1 spi_sck = 1'b0;
    endtask
    // burst: address steps after each byte
    task automatic xfer(input logic rd, input logic [6:0] a, input int n,
            input logic bad);
        logic q;
        logic [7:0] c;
        c = {rd, a};
        @(posedge clk_sys);
        #1 spi_cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) sbit(c[i], q);
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                sbit(dat[k][i], q);
                c[i] = q;
            end
            if (rd) dat[k] = c;
            else sbit(~^dat[k] ^ bad, q);
        end
        repeat (4) @(posedge clk_sys);
        #1 spi_cs_n = 1'b1;
    endtask
endmodule // spi_host

// ===== bench/testbench.sv
// self-checking bench for the status and channel bank block
`timescale 1ns/100ps
module testbench;
    logic clk_sys = 1'b0, rst_n = 1'b0, osc_ready = 1'b1, standby = 1'b0;
    logic tx_start = 1'b0, tx_stop = 1'b0, synth_lock = 1'b0;
    logic below_2v4 = 1'b0, below_2v1 = 1'b0, below_1v75 = 1'b0;
    logic [1:0] bank_sel = 2'h0;
    wire spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
    wire synth_load, tx_enable, force_reset;
    wire [31:0] synth_word;
    logic [31:0] lfsr_st = 32'h0000_7669;
    logic [7:0] bank [0:15];
    int mismatches = 0;
    int total_checks = 0;
    always #25 clk_sys = ~clk_sys;
    tx_regs i_tx_regs (.clk_sys(clk_sys), .rst_n(rst_n),
        .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .osc_ready(osc_ready), .standby(standby), .tx_start(tx_start),
        .bank_sel(bank_sel), .tx_stop(tx_stop), .synth_lock(synth_lock),
        .below_2v4(below_2v4), .below_2v1(below_2v1),
        .below_1v75(below_1v75), .synth_word(synth_word),
        .synth_load(synth_load), .tx_enable(tx_enable),
        .force_reset(force_reset));
    spi_host i_spi_host (.clk_sys(clk_sys), .spi_cs_n(spi_cs_n),
        .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe));
    function automatic logic [31:0] nxt_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // flags given as {close, early, brown, parity, lock}
    function automatic logic [7:0] exp_st(input logic [4:0] f);
        return {2'b10, f[4:3], 1'b0, f[2:0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic rd_st(input logic [4:0] f);
        i_spi_host.xfer(1'b1, 7'h01, 1, 1'b0);
        check(i_spi_host.dat[0], exp_st(f));
    endtask
    task automatic start_tx(input logic [1:0] b);
        bank_sel = b;
        tx_start = 1'b1;
        tick(1);
        tx_start = 1'b0;
    endtask
    // m selects {load, enable, reset}; v is the awaited value
    task automatic wait_for(input logic [2:0] m, input logic [2:0] v,
            input int lim);
        int n;
        n = 0;
        while ((({synth_load, tx_enable, force_reset} & m) !== v)
                && n < lim) begin
            tick(1);
            n++;
        end
        if (n >= lim) begin
            mismatches++;
            end_sim();
        end
    endtask
    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    initial begin
        tick(16);
        rst_n = 1'b1;
        rd_st(5'h04);
        rd_st(5'h00);
        osc_ready = 1'b0;
        for (int k = 0; k < 16; k++) begin
            lfsr_st = nxt_rand(lfsr_st);
            bank[k] = lfsr_st[7:0];
            i_spi_host.dat[k] = bank[k];
        end
        i_spi_host.xfer(1'b0, 7'h09, 16, 1'b0);
        start_tx(2'h0);
        tick(4);
        check(synth_word, 32'h0000_0000);
        osc_ready = 1'b1;
        i_spi_host.xfer(1'b1, 7'h09, 16, 1'b0);
        for (int k = 0; k < 16; k++) check(i_spi_host.dat[k], bank[k]);
        i_spi_host.dat[0] = 8'h5a;
        i_spi_host.dat[1] = 8'hc3;
        i_spi_host.xfer(1'b0, 7'h27, 2, 1'b0);
        i_spi_host.xfer(1'b1, 7'h27, 2, 1'b0);
        check(i_spi_host.dat[0], 8'h5a);
        check(i_spi_host.dat[1], 8'h00);
        i_spi_host.dat[0] = ~bank[0];
        i_spi_host.xfer(1'b0, 7'h09, 1, 1'b1);
        rd_st(5'h02);
        i_spi_host.xfer(1'b1, 7'h09, 1, 1'b0);
        check(i_spi_host.dat[0], bank[0]);
        for (int b = 0; b < 4; b++) begin
            start_tx(b[1:0]);
            wait_for(3'b100, 3'b100, 3);
            check(synth_word, {bank[4*b], bank[4*b+1], bank[4*b+2],
                bank[4*b+3]});
            lfsr_st = nxt_rand(lfsr_st);
            tick(lfsr_st[4:0]);
            synth_lock = 1'b1;
            wait_for(3'b010, 3'b010, 4);
            tx_stop = 1'b1;
            tick(1);
            tx_stop = 1'b0;
            wait_for(3'b010, 3'b000, 3);
            synth_lock = 1'b0;
            rd_st(5'h00);
        end
        start_tx(2'h3);
        tick(2100);
        check(tx_enable, 1'b0);
        rd_st(5'h01);
        standby = 1'b1;
        below_2v4 = 1'b1;
        below_2v1 = 1'b1;
        tick(5);
        start_tx(2'h2);
        check(synth_load, 1'b0);
        {below_2v4, below_2v1, standby} = 3'b000;
        tick(2);
        rd_st(5'h00);
        below_2v4 = 1'b1;
        tick(3);
        below_2v4 = 1'b0;
        tick(3);
        rd_st(5'h08);
        {below_2v4, below_2v1} = 2'b11;
        tick(3);
        {below_2v4, below_2v1} = 2'b00;
        tick(3);
        rd_st(5'h18);
        start_tx(2'h1);
        synth_lock = 1'b1;
        wait_for(3'b010, 3'b010, 6);
        below_1v75 = 1'b1;
        wait_for(3'b010, 3'b000, 2);
        wait_for(3'b001, 3'b001, 4);
        tick(5);
        check(force_reset, 1'b1);
        below_1v75 = 1'b0;
        synth_lock = 1'b0;
        wait_for(3'b001, 3'b000, 4);
        rd_st(5'h04);
        i_spi_host.xfer(1'b1, 7'h09, 1, 1'b0);
        check(i_spi_host.dat[0], 8'h00);
        // single channel: only the first bank is programmed
        for (int k = 0; k < 4; k++) begin
            lfsr_st = nxt_rand(lfsr_st);
            bank[k] = lfsr_st[7:0];
            i_spi_host.dat[k] = bank[k];
        end
        i_spi_host.xfer(1'b0, 7'h09, 4, 1'b0);
        start_tx(2'h0);
        check(synth_load, 1'b1);
        check(synth_word, {bank[0], bank[1], bank[2], bank[3]});
        end_sim();
    end
endmodule // testbench
bind tx_regs tx_regs_asserts i_tx_regs_asserts (.clk_sys(clk_sys),
    .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
    .osc_ready(osc_ready), .standby(standby), .tx_start(tx_start),
    .synth_lock(synth_lock), .below_1v75(below_1v75),
    .synth_load(synth_load), .tx_enable(tx_enable),
    .force_reset(force_reset));
